// >>> hdl/sbc_pick.sv
// Unpacks the four channels of one border colour encoding from the record.
`timescale 1ns/10ps
module sbc_pick (
   input wire sbc_pkg::sbc_enc_t enc,
   sbc_rec_if.view rec,
   output logic [sbc_pkg::DATA_W-1:0] red,
   output logic [sbc_pkg::DATA_W-1:0] green,
   output logic [sbc_pkg::DATA_W-1:0] blue,
   output logic [sbc_pkg::DATA_W-1:0] alpha
);
   // ----------------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------------
   // Normalised values are widened, signed ones with sign extension, so the
   // filter path always sees 32-bit channels.
   wire [31:0] un8 = rec.words[sbc_pkg::W_UNSIGNED_NORM_8BIT];
   wire [31:0] sn8 = rec.words[sbc_pkg::W_SIGNED_NORM_8BIT];
   wire [31:0] hrg = rec.words[sbc_pkg::W_HALF_RG];
   wire [31:0] hba = rec.words[sbc_pkg::W_HALF_BA];
   wire [31:0] urg = rec.words[sbc_pkg::W_UN16_RG];
   wire [31:0] uba = rec.words[sbc_pkg::W_UN16_BA];
   wire [31:0] srg = rec.words[sbc_pkg::W_SN16_RG];
   wire [31:0] sba = rec.words[sbc_pkg::W_SN16_BA];

   // Channel selection by encoding.
   always_comb begin
      red = rec.words[sbc_pkg::W_FLT_R];
      green = rec.words[sbc_pkg::W_FLT_G];
      blue = rec.words[sbc_pkg::W_FLT_B];
      alpha = rec.words[sbc_pkg::W_FLT_A];
      case (enc)
         sbc_pkg::ENC_UNSIGNED_NORM_8BIT: begin
            red = {24'h00_0000, un8[7:0]};
            green = {24'h00_0000, un8[15:8]};
            blue = {24'h00_0000, un8[23:16]};
            alpha = {24'h00_0000, un8[31:24]};
         end
         sbc_pkg::ENC_SIGNED_NORM_8BIT: begin
            red = {{24{sn8[7]}}, sn8[7:0]};
            green = {{24{sn8[15]}}, sn8[15:8]};
            blue = {{24{sn8[23]}}, sn8[23:16]};
            alpha = {{24{sn8[31]}}, sn8[31:24]};
         end
         sbc_pkg::ENC_HALF: begin
            red = {16'h0000, hrg[15:0]};
            green = {16'h0000, hrg[31:16]};
            blue = {16'h0000, hba[15:0]};
            alpha = {16'h0000, hba[31:16]};
         end
         sbc_pkg::ENC_UNSIGNED_NORM_16BIT: begin
            red = {16'h0000, urg[15:0]};
            green = {16'h0000, urg[31:16]};
            blue = {16'h0000, uba[15:0]};
            alpha = {16'h0000, uba[31:16]};
         end
         sbc_pkg::ENC_SIGNED_NORM_16BIT: begin
            red = {{16{srg[15]}}, srg[15:0]};
            green = {{16{srg[31]}}, srg[31:16]};
            blue = {{16{sba[15]}}, sba[15:0]};
            alpha = {{16{sba[31]}}, sba[31:16]};
         end
         default: begin
         end
      endcase
   end
endmodule

// >>> hdl/sbc_pkg.sv
// Shared constants and types for the sampler border colour select block.
package sbc_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NUM_WORDS = 12;
   localparam int WIDX_W = 4;
   localparam logic [ADDR_W-1:0] OFF_BORDER_LAST = 8'h2c;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_LOD = 8'h34;
   localparam logic [ADDR_W-1:0] OFF_STAT = 8'h38;
   localparam int WORD_LSB = 2;

   // Record word indices.
   localparam logic [WIDX_W-1:0] W_UNSIGNED_NORM_8BIT = 4'h0;
   localparam logic [WIDX_W-1:0] W_FLT_R = 4'h1;
   localparam logic [WIDX_W-1:0] W_FLT_G = 4'h2;
   localparam logic [WIDX_W-1:0] W_FLT_B = 4'h3;
   localparam logic [WIDX_W-1:0] W_FLT_A = 4'h4;
   localparam logic [WIDX_W-1:0] W_HALF_RG = 4'h5;
   localparam logic [WIDX_W-1:0] W_HALF_BA = 4'h6;
   localparam logic [WIDX_W-1:0] W_UN16_RG = 4'h7;
   localparam logic [WIDX_W-1:0] W_UN16_BA = 4'h8;
   localparam logic [WIDX_W-1:0] W_SN16_RG = 4'h9;
   localparam logic [WIDX_W-1:0] W_SN16_BA = 4'ha;
   localparam logic [WIDX_W-1:0] W_SIGNED_NORM_8BIT = 4'hb;

   // Control register fields.
   localparam int CTRL_LEGACY = 0;
   localparam int CTRL_CHROMA_KEY = 1;
   localparam int CTRL_ANISO = 2;
   localparam int CTRL_NULL_SURF = 3;
   localparam int CTRL_SWZ_LSB = 4;
   localparam int SWZ_W = 3;
   localparam logic [SWZ_W-1:0] SWZ_CONST_ZERO = 3'h0;

   // Level-of-detail register: unsigned 4.8 fixed point fields.
   localparam int LOD_W = 12;
   localparam int LOD_FLOOR_LSB = 0;
   localparam int LOD_CEIL_LSB = 16;
   localparam logic [LOD_W-1:0] LOD_MAX = 12'he00;
   localparam logic [LOD_W-1:0] LOD_FLOOR_RST = 12'h000;
   localparam logic [LOD_W-1:0] LOD_CEIL_RST = 12'he00;

   // Status register fields.
   localparam int STAT_ENC_LSB = 0;
   localparam int STAT_CK_ANISO = 8;
   localparam int STAT_ANISO_LEG = 9;
   localparam int STAT_NULL_SWZ = 10;
   localparam int STAT_AUX_DROP = 11;

   // ----------------------------------------------------------------------
   // Encodings and format classes
   // ----------------------------------------------------------------------
   typedef enum logic [5:0] {
      ENC_UNSIGNED_NORM_8BIT = 6'b00_0001,
      ENC_SIGNED_NORM_8BIT = 6'b00_0010,
      ENC_UNSIGNED_NORM_16BIT = 6'b00_0100,
      ENC_SIGNED_NORM_16BIT = 6'b00_1000,
      ENC_HALF = 6'b01_0000,
      ENC_SINGLE = 6'b10_0000
   } sbc_enc_t;

   localparam int FMT_W = 3;
   localparam logic [FMT_W-1:0] FMT_UNSIGNED_NORM_8BIT = 3'h0;
   localparam logic [FMT_W-1:0] FMT_SIGNED_NORM_8BIT = 3'h1;
   localparam logic [FMT_W-1:0] FMT_UNSIGNED_NORM_16BIT = 3'h2;
   localparam logic [FMT_W-1:0] FMT_SIGNED_NORM_16BIT = 3'h3;
   localparam logic [FMT_W-1:0] FMT_HALF = 3'h4;
   localparam logic [FMT_W-1:0] FMT_SINGLE = 3'h5;

   localparam int AUX_W = 2;
   localparam logic [AUX_W-1:0] AUX_NONE = 2'h0;
   localparam logic [AUX_W-1:0] AUX_HIER_DEPTH = 2'h1;

   // Float32 alpha keeps ten fractional mantissa bits for the packed format.
   localparam logic [DATA_W-1:0] HALF_PREC_MASK = 32'hffff_e000;
   localparam int WGT_W = 16;
endpackage

// >>> hdl/sbc_rec_if.sv
// Carrier for the border colour record between storage and its users.
`timescale 1ns/10ps
interface sbc_rec_if;
   logic wr_en;
   logic [sbc_pkg::WIDX_W-1:0] widx;
   logic [sbc_pkg::DATA_W-1:0] wdata;
   logic [sbc_pkg::NUM_WORDS-1:0][sbc_pkg::DATA_W-1:0] words;

   modport store (input wr_en, input widx, input wdata, output words);
   modport view (input words);
endinterface

// >>> hdl/sbc_rec_store.sv
// Storage for the twelve-word border colour record.
`timescale 1ns/10ps
module sbc_rec_store #(
   parameter int NUM_WORDS = sbc_pkg::NUM_WORDS
) (
   input wire logic clk,
   input wire logic sys_rst,
   sbc_rec_if.store rec
);
   // ----------------------------------------------------------------------
   // Record words
   // ----------------------------------------------------------------------
   logic [NUM_WORDS-1:0][sbc_pkg::DATA_W-1:0] words_r;

   // Every word clears at reset so a record never read as stale garbage.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         words_r <= '0;
      end else if (rec.wr_en) begin
         words_r[rec.widx] <= rec.wdata;
      end
   end

   assign rec.words = words_r;
endmodule

// >>> hdl/sbc_top.sv
// Top of the sampler border colour select block with its register port.
//
// Behaviour
// - Encoding chosen from format class and convention.
// - Word 0 holds four unsigned 8-bit channels.
// - Words 1-4 hold float32 red, green, blue, alpha.
// - Words 5-6 hold half-float channel pairs.
// - Words 7-8 hold unsigned 16-bit channel pairs.
// - Words 9-10 hold signed 16-bit channel pairs.
// - Word 11 holds four signed 8-bit channels.
// - LOD fields span 0.0 to 14.0, eight fraction bits.
// - Hierarchical depth auxiliary surface treated as none.
// - Packed float10 alpha keeps half-float precision only when point sampling.
// - YUV tap discard weight counts luma plane only.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module sbc_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [sbc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [sbc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [sbc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic brd_req,
   input wire logic [sbc_pkg::FMT_W-1:0] fmt_class,
   input wire logic fmt_128bpt,
   input wire logic fmt_yuv,
   input wire logic fmt_packed_float10_alpha2,
   input wire logic point_sample,
   input wire logic [sbc_pkg::AUX_W-1:0] aux_mode_in,
   input wire logic [sbc_pkg::WGT_W-1:0] tap_weight_total,
   input wire logic [sbc_pkg::WGT_W-1:0] tap_weight_luma,
   output logic brd_valid,
   output logic [5:0] brd_enc,
   output logic [sbc_pkg::DATA_W-1:0] brd_red,
   output logic [sbc_pkg::DATA_W-1:0] brd_green,
   output logic [sbc_pkg::DATA_W-1:0] brd_blue,
   output logic [sbc_pkg::DATA_W-1:0] brd_alpha,
   output logic [sbc_pkg::AUX_W-1:0] aux_mode_eff,
   output logic [sbc_pkg::WGT_W-1:0] tap_weight_out,
   output logic [sbc_pkg::LOD_W-1:0] lod_floor,
   output logic [sbc_pkg::LOD_W-1:0] lod_ceiling
);
   // ----------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------
   sbc_rec_if rec ();

   logic [7:0] ctrl_r;
   logic [sbc_pkg::LOD_W-1:0] lod_floor_r;
   logic [sbc_pkg::LOD_W-1:0] lod_ceil_r;
   logic [sbc_pkg::DATA_W-1:0] rdata_r;
   logic [sbc_pkg::DATA_W-1:0] rdata_nxt;
   sbc_pkg::sbc_enc_t last_enc_r;

   // Record words sit at consecutive word addresses from zero.
   wire hit_rec = reg_addr <= sbc_pkg::OFF_BORDER_LAST;
   wire hit_ctrl = reg_addr == sbc_pkg::OFF_CTRL;
   wire hit_lod = reg_addr == sbc_pkg::OFF_LOD;
   wire hit_stat = reg_addr == sbc_pkg::OFF_STAT;
   wire [sbc_pkg::WIDX_W-1:0] widx = reg_addr[sbc_pkg::WORD_LSB +: sbc_pkg::WIDX_W];

   // An unaligned address up to 8'h2c aliases to its word; 8'h2d to 8'h2f are unmapped.
   assign rec.wr_en = reg_wr & hit_rec;
   assign rec.widx = widx;
   assign rec.wdata = reg_wdata;

   sbc_rec_store #(
      .NUM_WORDS(sbc_pkg::NUM_WORDS)
   ) u_store (
      .clk(clk),
      .sys_rst(sys_rst),
      .rec(rec.store)
   );

   // ----------------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------------
   wire legacy = ctrl_r[sbc_pkg::CTRL_LEGACY];
   wire chroma_key_en = ctrl_r[sbc_pkg::CTRL_CHROMA_KEY];
   wire aniso_en = ctrl_r[sbc_pkg::CTRL_ANISO];
   wire null_surface_type = ctrl_r[sbc_pkg::CTRL_NULL_SURF];
   wire [sbc_pkg::SWZ_W-1:0] alpha_swz = ctrl_r[sbc_pkg::CTRL_SWZ_LSB +: sbc_pkg::SWZ_W];

   // Out-of-range LOD writes saturate so the sampler never sees beyond 14.0.
   wire [sbc_pkg::LOD_W-1:0] floor_wr = reg_wdata[sbc_pkg::LOD_FLOOR_LSB +: sbc_pkg::LOD_W];
   wire [sbc_pkg::LOD_W-1:0] ceil_wr = reg_wdata[sbc_pkg::LOD_CEIL_LSB +: sbc_pkg::LOD_W];
   wire [sbc_pkg::LOD_W-1:0] floor_nxt = (floor_wr > sbc_pkg::LOD_MAX) ?
                                         sbc_pkg::LOD_MAX : floor_wr;
   wire [sbc_pkg::LOD_W-1:0] ceil_nxt = (ceil_wr > sbc_pkg::LOD_MAX) ?
                                        sbc_pkg::LOD_MAX : ceil_wr;

   // Control and LOD registers.
   // A floor above the ceiling is kept; software owns that order.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r <= 8'h00;
         lod_floor_r <= sbc_pkg::LOD_FLOOR_RST;
         lod_ceil_r <= sbc_pkg::LOD_CEIL_RST;
      end else if (reg_wr & hit_ctrl) begin
         ctrl_r <= reg_wdata[7:0];
      end else if (reg_wr & hit_lod) begin
         lod_floor_r <= floor_nxt;
         lod_ceil_r <= ceil_nxt;
      end
   end

   assign lod_floor = lod_floor_r;
   assign lod_ceiling = lod_ceil_r;

   // ----------------------------------------------------------------------
   // Encoding selection
   // ----------------------------------------------------------------------
   // The legacy convention always takes the float32 words; otherwise the
   // encoding follows the texel format class, with float32 as fallback.
   wire sbc_pkg::sbc_enc_t sel_enc =
      legacy ? sbc_pkg::ENC_SINGLE :
      (fmt_class == sbc_pkg::FMT_UNSIGNED_NORM_8BIT) ? sbc_pkg::ENC_UNSIGNED_NORM_8BIT :
      (fmt_class == sbc_pkg::FMT_SIGNED_NORM_8BIT) ? sbc_pkg::ENC_SIGNED_NORM_8BIT :
      (fmt_class == sbc_pkg::FMT_UNSIGNED_NORM_16BIT) ? sbc_pkg::ENC_UNSIGNED_NORM_16BIT :
      (fmt_class == sbc_pkg::FMT_SIGNED_NORM_16BIT) ? sbc_pkg::ENC_SIGNED_NORM_16BIT :
      (fmt_class == sbc_pkg::FMT_HALF) ? sbc_pkg::ENC_HALF : sbc_pkg::ENC_SINGLE;

   logic [sbc_pkg::DATA_W-1:0] pick_r;
   logic [sbc_pkg::DATA_W-1:0] pick_g;
   logic [sbc_pkg::DATA_W-1:0] pick_b;
   logic [sbc_pkg::DATA_W-1:0] pick_a;

   sbc_pick u_pick (
      .enc(sel_enc),
      .rec(rec.view),
      .red(pick_r),
      .green(pick_g),
      .blue(pick_b),
      .alpha(pick_a)
   );

   // Alpha of the packed float10 format is cut to half-float precision when point_sample is set.
   wire trim_alpha = fmt_packed_float10_alpha2 & point_sample;
   wire [sbc_pkg::DATA_W-1:0] alpha_nxt = trim_alpha ?
                                          (pick_a & sbc_pkg::HALF_PREC_MASK) : pick_a;
   // Hierarchical depth is dropped, not refused, so sampling goes on.
   wire [sbc_pkg::AUX_W-1:0] aux_nxt = (aux_mode_in == sbc_pkg::AUX_HIER_DEPTH) ?
                                       sbc_pkg::AUX_NONE : aux_mode_in;
   wire [sbc_pkg::WGT_W-1:0] wgt_nxt = fmt_yuv ? tap_weight_luma : tap_weight_total;

   // ----------------------------------------------------------------------
   // Substitute texel output
   // ----------------------------------------------------------------------
   // Border answer one cycle after the request; data hold until the next one.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         brd_valid <= 1'b0;
         brd_enc <= sbc_pkg::ENC_SINGLE;
         brd_red <= '0;
         brd_green <= '0;
         brd_blue <= '0;
         brd_alpha <= '0;
         aux_mode_eff <= sbc_pkg::AUX_NONE;
         tap_weight_out <= '0;
         last_enc_r <= sbc_pkg::ENC_SINGLE;
      end else begin
         brd_valid <= brd_req;
         if (brd_req) begin
            brd_enc <= sel_enc;
            brd_red <= pick_r;
            brd_green <= pick_g;
            brd_blue <= pick_b;
            brd_alpha <= alpha_nxt;
            aux_mode_eff <= aux_nxt;
            tap_weight_out <= wgt_nxt;
            last_enc_r <= sel_enc;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Status and read-back
   // ----------------------------------------------------------------------
   // Programming checks are live levels; software reads them to debug setup.
   wire ck_aniso_bad = chroma_key_en & aniso_en;
   wire aniso_leg_bad = aniso_en & legacy & fmt_128bpt;
   wire null_swz_bad = null_surface_type & (alpha_swz != sbc_pkg::SWZ_CONST_ZERO);
   wire aux_drop = aux_mode_in == sbc_pkg::AUX_HIER_DEPTH;
   wire [sbc_pkg::DATA_W-1:0] stat_word = (32'h0000_0000 |
      (32'(last_enc_r) << sbc_pkg::STAT_ENC_LSB) |
      (32'(ck_aniso_bad) << sbc_pkg::STAT_CK_ANISO) |
      (32'(aniso_leg_bad) << sbc_pkg::STAT_ANISO_LEG) |
      (32'(null_swz_bad) << sbc_pkg::STAT_NULL_SWZ) |
      (32'(aux_drop) << sbc_pkg::STAT_AUX_DROP));
   wire [sbc_pkg::DATA_W-1:0] lod_word = (32'(lod_floor_r) << sbc_pkg::LOD_FLOOR_LSB) |
                                         (32'(lod_ceil_r) << sbc_pkg::LOD_CEIL_LSB);

   // Unmapped addresses read as zero.
   assign rdata_nxt = !reg_rd ? 32'h0000_0000 :
                      hit_rec ? rec.words[widx] :
                      hit_ctrl ? {24'h00_0000, ctrl_r} :
                      hit_lod ? lod_word :
                      hit_stat ? stat_word : 32'h0000_0000;

   // Read data stand only in the cycle after the strobe.
   // Registering costs a cycle but keeps the read path short.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   // One clock domain, so the defaults below serve every check.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   answer_next_cycle_a: assert property (brd_req |=> brd_valid)
      else $error("border answer missing one cycle after request");
   legacy_picks_float_a: assert property (brd_req && legacy |=> brd_enc == 6'b10_0000)
      else $error("legacy convention did not select float32 words");
   class_picks_unsigned_norm_8bit_a: assert property (brd_req && !legacy &&
      fmt_class == sbc_pkg::FMT_UNSIGNED_NORM_8BIT |=> brd_enc == 6'b00_0001)
      else $error("unsigned_norm_8bit class did not select unsigned_norm_8bit words");
   unsigned_norm_8bit_unpack_a: assert property (brd_valid && brd_enc == 6'b00_0001 && $past(brd_req)
      |-> brd_green == {24'h00_0000, $past(rec.words[0][15:8])})
      else $error("unsigned_norm_8bit green taken from wrong bits");
   float_unpack_a: assert property (brd_valid && brd_enc == 6'b10_0000
      && !$past(trim_alpha) |-> brd_alpha == $past(rec.words[4]))
      else $error("float32 alpha not taken from word four");
   half_unpack_a: assert property (brd_valid && brd_enc == 6'b01_0000
      |-> brd_blue[15:0] == $past(rec.words[6][15:0]))
      else $error("half blue not taken from word six low half");
   unsigned_norm_16bit_unpack_a: assert property (brd_valid && brd_enc == 6'b00_0100
      |-> brd_green[15:0] == $past(rec.words[7][31:16]))
      else $error("unsigned_norm_16bit green not taken from word seven high half");
   signed_norm_16bit_unpack_a: assert property (brd_valid && brd_enc == 6'b00_1000
      |-> brd_red == {{16{$past(rec.words[9][15])}}, $past(rec.words[9][15:0])})
      else $error("signed_norm_16bit red not sign extended from word nine");
   signed_norm_8bit_unpack_a: assert property (brd_valid && brd_enc == 6'b00_0010
      |-> brd_blue[7:0] == $past(rec.words[11][23:16]))
      else $error("signed_norm_8bit blue not taken from word eleven");
   lod_range_a: assert property (lod_floor_r <= 12'he00 && lod_ceil_r <= 12'he00)
      else $error("level of detail field above 14.0");
   hier_aux_drop_a: assert property (brd_req && aux_mode_in == 2'h1
      |=> aux_mode_eff == 2'h0)
      else $error("hierarchical depth auxiliary surface not ignored");
   alpha_precision_a: assert property (brd_req && trim_alpha
      |=> brd_alpha[12:0] == 13'h0000)
      else $error("packed float10 alpha keeps too much precision");
   luma_weight_a: assert property (brd_req && fmt_yuv
      |=> tap_weight_out == $past(tap_weight_luma))
      else $error("yuv weight includes chroma planes");

   // Answer timing, hold, half selection, signed 8-bit unpack and pass-through fields.
   valid_needs_req_a: assert property (!brd_req
      |=> !brd_valid)
      else $error("border answer without request");
   data_hold_a: assert property (!brd_req
      |=> $stable(brd_red) && $stable(brd_alpha))
      else $error("border data changed without request");
   class_picks_half_a: assert property (brd_req && !legacy
      && fmt_class == sbc_pkg::FMT_HALF |=> brd_enc == 6'b01_0000)
      else $error("half class did not select half words");
   signed_norm_8bit_red_a: assert property (brd_valid && brd_enc == 6'b00_0010
      |-> brd_red == {{24{$past(rec.words[11][7])}}, $past(rec.words[11][7:0])})
      else $error("signed_norm_8bit red not sign extended");
   aux_kept_a: assert property (brd_req && aux_mode_in != 2'h1
      |=> aux_mode_eff == $past(aux_mode_in))
      else $error("auxiliary mode altered");
   total_weight_a: assert property (brd_req && !fmt_yuv
      |=> tap_weight_out == $past(tap_weight_total))
      else $error("weight not the total for a non-yuv surface");
   lod_kept_a: assert property (reg_wr && hit_lod && floor_wr <= 12'he00
      |=> lod_floor_r == $past(floor_wr))
      else $error("level of detail fraction bits lost");
   rdata_idle_a: assert property (!reg_rd
      |=> reg_rdata == 32'h0000_0000)
      else $error("read data without read strobe");

   // ----------------------------------------------------------------------
   // Coverage
   // ----------------------------------------------------------------------
   legacy_seen_c: cover property (brd_req && legacy ##1 brd_valid);
   half_seen_c: cover property (brd_valid && brd_enc == 6'b01_0000);
   back_to_back_c: cover property (brd_req ##1 brd_req ##1 brd_valid);
   lod_clamp_c: cover property (reg_wr && hit_lod && reg_wdata[11:0] > 12'he00);
   status_read_c: cover property (reg_rd && hit_stat);
endmodule

// >>> tb/sampler_border_color_select_tb.sv
// Self-checking bench for the sampler border colour select block.
`timescale 1ns/10ps
module sampler_border_color_select_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic start = 1'b0;
   logic [2:0] fmt_class = 3'h0;
   logic fmt_yuv = 1'b0;
   logic fmt_pf = 1'b0;
   logic point_sample = 1'b0;
   logic f128 = 1'b0;
   logic [1:0] aux_in = 2'h0;
   logic [31:0] reg_rdata, red, green, blue, alpha, rd_v;
   logic brd_req, brd_valid, miss;
   logic [1:0] aux_eff;
   logic [15:0] w_out;
   logic [5:0] enc;
   logic [11:0] lod_lo, lod_hi;
   logic [3:0][31:0] cap;
   int n_mismatch = 0;
   int checks_done = 0;

   initial forever #12.5 clk = ~clk;

   sbc_top i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .brd_req(brd_req),
      .fmt_class(fmt_class), .fmt_128bpt(f128), .fmt_yuv(fmt_yuv),
      .fmt_packed_float10_alpha2(fmt_pf), .point_sample(point_sample), .aux_mode_in(aux_in),
      .tap_weight_total(16'h1234), .tap_weight_luma(16'h0456), .brd_valid(brd_valid),
      .brd_enc(enc), .brd_red(red), .brd_green(green), .brd_blue(blue), .brd_alpha(alpha),
      .aux_mode_eff(aux_eff), .tap_weight_out(w_out), .lod_floor(lod_lo), .lod_ceiling(lod_hi));

   sbc_sampler_model i_sampler (.clk(clk), .sys_rst(sys_rst), .start(start),
      .brd_req(brd_req),
      .brd_valid(brd_valid), .brd_red(red), .brd_green(green), .brd_blue(blue),
      .brd_alpha(alpha), .cap(cap), .miss(miss));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   // Record word i; mixed sign bits in bytes and halves expose extension slips.
   function automatic logic [31:0] wv(input int i);
      return 32'hfe81_7f02 ^ (32'h0101_0101 * i[31:0]);
   endfunction

   // Channels {alpha, blue, green, red} expected for one format class.
   function automatic logic [3:0][31:0] ex(input int f);
      logic [31:0] a;
      logic [31:0] b;
      a = wv(f == 1 ? 11 : f == 4 ? 5 : 2 * f + 3);
      b = wv(f == 4 ? 6 : 2 * f + 4);
      case (f)
         0: return {32'(wv(0) >> 24), 32'(wv(0) >> 16 & 255), 32'(wv(0) >> 8 & 255),
                    32'(wv(0) & 255)};
         1: return {32'($signed(a[31:24])), 32'($signed(a[23:16])), 32'($signed(a[15:8])),
                    32'($signed(a[7:0]))};
         2, 4: return {32'(b[31:16]), 32'(b[15:0]), 32'(a[31:16]), 32'(a[15:0])};
         3: return {32'($signed(b[31:16])), 32'($signed(b[15:0])), 32'($signed(a[31:16])),
                    32'($signed(a[15:0]))};
         default: return {wv(4), wv(3), wv(2), wv(1)};
      endcase
   endfunction

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic fetch(input logic [2:0] f);
      @(posedge clk);
      fmt_class <= f;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_reset_map();
      chk("enc after reset", enc, 32'h0000_0020);
      rd(8'h34, rd_v);
      chk("lod reset", rd_v, 32'h0e00_0000);
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, rd_v);
      chk("unmapped read", rd_v, 32'h0000_0000);
      for (int i = 0; i < 12; i++) wr(8'(4 * i), wv(i));
      for (int i = 0; i < 12; i++) begin
         rd(8'(4 * i), rd_v);
         chk("record word", rd_v, wv(i));
      end
   endtask

   // Every class, plus the two unknown codes that fall back to single float.
   task automatic t_select();
      logic [3:0][31:0] e;
      for (int f = 0; f < 8; f++) begin
         fetch(3'(f));
         e = ex(f);
         chk("enc", enc, f < 6 ? 32'h1 << f : 32'h0000_0020);
         for (int c = 0; c < 4; c++) begin
            chk("channel", cap[c], e[c]);
         end
      end
      wr(8'h30, 32'h0000_0001);
      fetch(3'h2);
      chk("legacy enc", enc, 32'h0000_0020);
      chk("legacy red", cap[0], wv(1));
   endtask

   task automatic t_sideband();
      @(posedge clk);
      fmt_pf <= 1'b1;
      point_sample <= 1'b1;
      aux_in <= 2'h1;
      fmt_yuv <= 1'b1;
      fetch(3'h5);
      chk("trimmed alpha", cap[3], wv(4) & sbc_pkg::HALF_PREC_MASK);
      chk("aux dropped", aux_eff, 32'h0000_0000);
      chk("luma weight", w_out, 32'h0000_0456);
      @(posedge clk);
      aux_in <= 2'h2;
      fmt_yuv <= 1'b0;
      point_sample <= 1'b0;
      fetch(3'h5);
      chk("full alpha", cap[3], wv(4));
      chk("aux kept", aux_eff, 32'h0000_0002);
      chk("total weight", w_out, 32'h0000_1234);
   endtask

   task automatic t_lod();
      wr(8'h34, 32'h0f00_0fff);
      rd(8'h34, rd_v);
      chk("lod saturate", rd_v, 32'h0e00_0e00);
      chk("floor out", lod_lo, 32'h0000_0e00);
      wr(8'h34, 32'h0c80_0181);
      rd(8'h34, rd_v);
      chk("lod fraction", rd_v, 32'h0c80_0181);
      chk("ceiling out", lod_hi, 32'h0000_0c80);
   endtask

   // Breaks the software-only pairings, with no fetch issued, to see the flags.
   task automatic t_status();
      @(posedge clk);
      f128 <= 1'b1;
      aux_in <= 2'h1;
      wr(8'h30, 32'h0000_001f);
      rd(8'h38, rd_v);
      chk("status", rd_v, 32'h0000_0f20);
      rd(8'h30, rd_v);
      chk("ctrl", rd_v, 32'h0000_001f);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // The whole sequence needs well under a thousand cycles.
   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset_map();
      t_select();
      t_sideband();
      t_lod();
      t_status();
      chk("answer timing", miss, 32'h0000_0000);
      final_report();
   end
endmodule

// >>> tb/sbc_sampler_model.sv
// Behavioural texture sampler pipeline that fetches border colours.
`timescale 1ns/10ps
module sbc_sampler_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   output logic brd_req = 1'b0,
   input wire logic brd_valid,
   input wire logic [sbc_pkg::DATA_W-1:0] brd_red,
   input wire logic [sbc_pkg::DATA_W-1:0] brd_green,
   input wire logic [sbc_pkg::DATA_W-1:0] brd_blue,
   input wire logic [sbc_pkg::DATA_W-1:0] brd_alpha,
   output logic [3:0][sbc_pkg::DATA_W-1:0] cap,
   output logic miss = 1'b0
);
   logic pend_r = 1'b0;

   // One-cycle fetch pulse; the answer must come exactly one cycle later.
   // A late or spurious answer is remembered, since the pipeline cannot wait.
   // One valid configuration and descriptor per fetch.
   always_ff @(posedge clk) begin
      brd_req <= start;
      pend_r <= brd_req;
      if (brd_valid) begin
         cap <= {brd_alpha, brd_blue, brd_green, brd_red};
      end
      if (!sys_rst && pend_r !== brd_valid) begin
         miss <= 1'b1;
      end
   end
endmodule
